// *** design/acmt_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the converter control.
// Assumes: 32-bit APB data, one register per aligned word, 100 MHz system clock.
// Notes:   Byte address of a register is four times its index.
`ifndef ACMT_CONSTS_SVH
`define ACMT_CONSTS_SVH

`define ACMT_IDX_MODE_TIMING    10'h086
`define ACMT_IDX_DELAY_LOW      10'h0E3
`define ACMT_IDX_CTRL_TWO       10'h0E2
`define ACMT_IDX_CTRL_ZERO      10'h0E8
`define ACMT_IDX_CTRL_ONE       10'h0E1
`define ACMT_IDX_AUX            10'h0A2
`define ACMT_IDX_IRQ_STATUS     10'h0F0
`define ACMT_IDX_IRQ_MASK       10'h0F1

`define ACMT_ADDR_MODE_TIMING   {`ACMT_IDX_MODE_TIMING, 2'b00}
`define ACMT_ADDR_DELAY_LOW     {`ACMT_IDX_DELAY_LOW, 2'b00}
`define ACMT_ADDR_CTRL_TWO      {`ACMT_IDX_CTRL_TWO, 2'b00}
`define ACMT_ADDR_CTRL_ZERO     {`ACMT_IDX_CTRL_ZERO, 2'b00}
`define ACMT_ADDR_CTRL_ONE      {`ACMT_IDX_CTRL_ONE, 2'b00}
`define ACMT_ADDR_AUX           {`ACMT_IDX_AUX, 2'b00}
`define ACMT_ADDR_IRQ_STATUS    {`ACMT_IDX_IRQ_STATUS, 2'b00}
`define ACMT_ADDR_IRQ_MASK      {`ACMT_IDX_IRQ_MASK, 2'b00}

`define ACMT_MT_HALF_IRQ_EN     5
`define ACMT_MT_CONTINUOUS_SAMPLING_SELECT            4
`define ACMT_MT_AQT_HI          3
`define ACMT_MT_AQT_LO          1
`define ACMT_MT_SLOW            0
`define ACMT_C0_FLAG            7
`define ACMT_C0_START           6
`define ACMT_C0_SRC_HI          5
`define ACMT_C0_SRC_LO          4
`define ACMT_C1_EXT_EN          1
`define ACMT_C1_DIV_HI          6
`define ACMT_C1_DIV_LO          4
`define ACMT_C2_DLY_MSB         0
`define ACMT_AUX_SLOW           4
`define ACMT_IRQ_DONE           0
`define ACMT_IRQ_HALF           1

`define ACMT_RESET_BYTE         8'h00
`define ACMT_UPPER_CHAN_FIRST   4'h9
`define ACMT_AQT_BASE           6'h06
`define ACMT_SEQ_COUNT          8'h08
`define ACMT_SEQ_HALF           (`ACMT_SEQ_COUNT >> 1)

`define ACMT_CLK_NS             10
`define ACMT_CONV_FAST_NS       1400
`define ACMT_CONV_SLOW_NS       4750
`define ACMT_CONV_FAST_CYC      ((`ACMT_CONV_FAST_NS + `ACMT_CLK_NS - 1) / `ACMT_CLK_NS)
`define ACMT_CONV_SLOW_CYC      ((`ACMT_CONV_SLOW_NS + `ACMT_CLK_NS - 1) / `ACMT_CLK_NS)

`endif

// *** design/acmt_ctrl.sv ***
// Purpose: Mode, acquisition, speed and trigger-delay control of the converter.
// Assumes: APB slave with one wait state; trigger inputs synchronous to CLK_IN.
// Notes:   Conversion timing is counted here; the analog core follows the outputs.
// How it works
// RULE_01 - Half-done enable raises the interrupt at half the continuous sequence.
// RULE_02 - Single mode raises the interrupt after every conversion.
// RULE_03 - Without half-done enable, continuous mode raises the interrupt only after the whole sequence.
// RULE_04 - Upper channels sample for four times the field plus six clocks.
// RULE_05 - Reset acquisition field zero gives the minimum six-clock window.
// RULE_06 - Software keeps the window above 370 ns by its field choice.
// RULE_07 - Software leaves the acquisition field alone during a conversion.
// RULE_08 - Speed bit clear gives the 1400 ns fast conversion.
// RULE_09 - Speed bit set gives the 4750 ns slow conversion.
// RULE_10 - Slow mode is the OR of local and auxiliary slow bits.
// RULE_11 - Delay low byte plus control-two bit 0 form a 9-bit delay.
// RULE_12 - An external trigger waits the delay in converter clocks, then converts.
// RULE_13 - The delay applies only while external triggering is enabled.
// RULE_14 - Software keeps the delay fixed while a pulse-width trigger runs.
// RULE_15 - Start comes from software or external trigger; busy ignores triggers.
// RULE_16 - Completion sets the flag; no start until software clears it.
// RULE_17 - Source field picks pulse-width channel 0, 2, 4 or start pin.
// RULE_18 - Sequence length is a fixed count; half point rounds down.
`include "acmt_consts.svh"
module acmt_ctrl
   import acmt_pkg::*;
(
   input  wire logic        CLK_IN,
   input  wire logic        SYS_RST_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [11:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output      logic [31:0] PRDATA_OUT,
   output      logic        PREADY_OUT,
   output      logic        PSLVERR_OUT,
   input  wire logic [3:0]  TRIG_IN,
   output      logic        IRQ_OUT,
   output      logic        SAMPLE_OUT,
   output      logic        CONVERT_OUT,
   output      logic        SLOW_OUT,
   output      logic [3:0]  CHANNEL_OUT
);

   acmt_regs_t r_q;
   acmt_regs_t r_d;
   acmt_dly_if dly_link ();

   acmt_trig_delay u_delay (
      .clk (CLK_IN),
      .rst (SYS_RST_IN),
      .dly (dly_link)
   );

   assign dly_link.load  = r_q.dly_load;
   assign dly_link.value = {r_q.dly_msb, r_q.dly_low};
   assign dly_link.tick  = r_q.tick;

   assign PRDATA_OUT  = r_q.prdata;
   assign PREADY_OUT  = r_q.pready;
   assign PSLVERR_OUT = r_q.pslverr;
   assign IRQ_OUT     = r_q.irq;
   assign SAMPLE_OUT  = r_q.sample;
   assign CONVERT_OUT = r_q.convert;
   assign SLOW_OUT    = r_q.slow;
   assign CHANNEL_OUT = r_q.chan;

   logic        access;
   logic        wr;
   logic        hit;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte;
   logic        trig_sel;
   logic        trig_edge;
   logic        sw_start;
   logic        can_start;
   logic [5:0]  acq_len;
   logic [8:0]  conv_last;
   logic        conv_end;
   logic [1:0]  irq_set;
   logic [7:0]  seq_next;

   always_comb begin
      r_d          = r_q;
      irq_set      = 2'b00;
      r_d.dly_load = 1'b0;
      access       = PSEL_IN && PENABLE_IN && !r_q.pready;
      wr           = PSEL_IN && PENABLE_IN && r_q.pready && PWRITE_IN && !r_q.pslverr;
      wbyte        = PWDATA_IN[7:0];
      hit          = 1'b1;
      rbyte        = 8'h00;
      seq_next     = r_q.seq + 8'h01;

      // Converter clock enable from the divider.
      r_d.tick = (r_q.div_cnt == r_q.div);
      r_d.div_cnt = r_d.tick ? 3'h0 : r_q.div_cnt + 3'h1;

      // RULE_17 trigger source select
      trig_sel      = TRIG_IN[r_q.src];
      r_d.trig_prev = trig_sel;
      trig_edge     = trig_sel && !r_q.trig_prev;

      // RULE_04 upper channel window
      acq_len = (r_q.chan >= `ACMT_UPPER_CHAN_FIRST) ?
                ({1'b0, r_q.aqt, 2'b00} + `ACMT_AQT_BASE) : `ACMT_AQT_BASE;
      // RULE_10 OR of slow bits
      r_d.slow  = r_q.slow_local || r_q.slow_aux;
      // RULE_08 fast conversion time
      conv_last = 9'(`ACMT_CONV_FAST_CYC - 1);
      // RULE_09 slow conversion time
      if (r_q.slow) begin
         conv_last = 9'(`ACMT_CONV_SLOW_CYC - 1);
      end
      conv_end = 1'b0;

      case (PADDR_IN)
         `ACMT_ADDR_MODE_TIMING: rbyte = {2'b00, r_q.half_irq_en, r_q.continuous_sampling_select,
                                          r_q.aqt, r_q.slow_local};
         `ACMT_ADDR_DELAY_LOW:   rbyte = r_q.dly_low;
         `ACMT_ADDR_CTRL_TWO:    rbyte = {7'h00, r_q.dly_msb};
         `ACMT_ADDR_CTRL_ZERO:   rbyte = {r_q.flag, r_q.state != ST_IDLE, r_q.src, r_q.chan};
         `ACMT_ADDR_CTRL_ONE:    rbyte = {1'b0, r_q.div, 2'b00, r_q.ext_en, 1'b0};
         `ACMT_ADDR_AUX:         rbyte = {3'h0, r_q.slow_aux, 4'h0};
         `ACMT_ADDR_IRQ_STATUS:  rbyte = {6'h00, r_q.irq_sts};
         `ACMT_ADDR_IRQ_MASK:    rbyte = {6'h00, r_q.irq_msk};
         default:                hit   = 1'b0;
      endcase

      // APB answer one cycle after the access phase opens.
      r_d.pready  = access;
      r_d.pslverr = access && !hit;
      r_d.prdata  = (access && !PWRITE_IN) ? {24'h000000, rbyte} : 32'h00000000;

      sw_start = 1'b0;
      if (wr) begin
         case (PADDR_IN)
            `ACMT_ADDR_MODE_TIMING: begin
               r_d.half_irq_en = wbyte[`ACMT_MT_HALF_IRQ_EN];
               r_d.continuous_sampling_select        = wbyte[`ACMT_MT_CONTINUOUS_SAMPLING_SELECT];
               r_d.aqt         = wbyte[`ACMT_MT_AQT_HI:`ACMT_MT_AQT_LO];
               r_d.slow_local  = wbyte[`ACMT_MT_SLOW];
            end
            // RULE_11 nine-bit delay value
            `ACMT_ADDR_DELAY_LOW: r_d.dly_low = wbyte;
            `ACMT_ADDR_CTRL_TWO:  r_d.dly_msb = wbyte[`ACMT_C2_DLY_MSB];
            `ACMT_ADDR_CTRL_ZERO: begin
               if (!wbyte[`ACMT_C0_FLAG]) begin
                  r_d.flag = 1'b0;
               end
               sw_start = wbyte[`ACMT_C0_START];
               r_d.src  = wbyte[`ACMT_C0_SRC_HI:`ACMT_C0_SRC_LO];
               r_d.chan = wbyte[3:0];
            end
            `ACMT_ADDR_CTRL_ONE: begin
               r_d.ext_en = wbyte[`ACMT_C1_EXT_EN];
               r_d.div    = wbyte[`ACMT_C1_DIV_HI:`ACMT_C1_DIV_LO];
            end
            `ACMT_ADDR_AUX:        r_d.slow_aux = wbyte[`ACMT_AUX_SLOW];
            `ACMT_ADDR_IRQ_STATUS: r_d.irq_sts  = r_q.irq_sts & ~wbyte[1:0];
            `ACMT_ADDR_IRQ_MASK:   r_d.irq_msk  = wbyte[1:0];
            default: begin
            end
         endcase
      end

      // RULE_16 flag blocks new starts
      can_start = (r_q.state == ST_IDLE) && !r_q.flag;

      case (r_q.state)
         ST_IDLE: begin
            r_d.seq = 8'h00;
            // RULE_15 software or external start
            if (can_start && sw_start) begin
               r_d.state = ST_ACQ;
               r_d.cnt   = 9'h000;
            // RULE_13 delay only with external trigger
            end else if (can_start && r_q.ext_en && trig_edge) begin
               r_d.state    = ST_DELAY;
               r_d.dly_load = 1'b1;
            end
         end
         ST_DELAY: begin
            // RULE_12 convert after delay
            if (dly_link.done) begin
               r_d.state = ST_ACQ;
               r_d.cnt   = 9'h000;
            end
         end
         ST_ACQ: begin
            // RULE_05 six-clock minimum window
            if (r_q.tick) begin
               if (r_q.cnt == {3'h0, acq_len - 6'h01}) begin
                  r_d.state = ST_CONV;
                  r_d.cnt   = 9'h000;
               end else begin
                  r_d.cnt = r_q.cnt + 9'h001;
               end
            end
         end
         ST_CONV: begin
            r_d.cnt  = r_q.cnt + 9'h001;
            conv_end = (r_q.cnt == conv_last);
            if (conv_end) begin
               r_d.cnt = 9'h000;
               r_d.seq = seq_next;
               if (!r_q.continuous_sampling_select) begin
                  // RULE_02 interrupt per conversion
                  r_d.state          = ST_IDLE;
                  r_d.flag           = 1'b1;
                  irq_set[`ACMT_IRQ_DONE] = 1'b1;
               end else if (seq_next == `ACMT_SEQ_COUNT) begin
                  // RULE_03 interrupt after full sequence
                  r_d.state          = ST_IDLE;
                  r_d.flag           = 1'b1;
                  irq_set[`ACMT_IRQ_DONE] = 1'b1;
               end else begin
                  r_d.state = ST_ACQ;
                  // RULE_18 half point rounds down
                  if (seq_next == 8'(`ACMT_SEQ_HALF)) begin
                     // RULE_01 half-done interrupt
                     irq_set[`ACMT_IRQ_DONE] = r_q.half_irq_en;
                     irq_set[`ACMT_IRQ_HALF] = r_q.half_irq_en;
                  end
               end
            end
         end
         default: r_d.state = ST_IDLE;
      endcase

      // Hardware set wins over a same-cycle software clear.
      r_d.irq_sts = r_d.irq_sts | irq_set;
      r_d.irq     = |(r_d.irq_sts & r_d.irq_msk);
      r_d.sample  = (r_d.state == ST_ACQ);
      r_d.convert = (r_d.state == ST_CONV);
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

endmodule // acmt_ctrl

// *** design/acmt_dly_if.sv ***
// Purpose: Link between the sequencer and the trigger delay counter.
// Assumes: One system clock for both ends.
// Notes:   The done strobe is one cycle long.
interface acmt_dly_if;
   logic       load;
   logic [8:0] value;
   logic       tick;
   logic       done;

   modport seq (output load, output value, output tick, input done);
   modport dly (input load, input value, input tick, output done);
endinterface : acmt_dly_if

// *** design/acmt_pkg.sv ***
// Purpose: Types shared by the converter control modules.
// Assumes: Constants come from the header.
// Notes:   Each module keeps all of its state in one packed struct.
`include "acmt_consts.svh"

package acmt_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DELAY,
      ST_ACQ,
      ST_CONV
   } acmt_state_t;

   typedef struct packed {
      logic [8:0] count;
      logic       running;
      logic       done;
   } acmt_dly_t;

   typedef struct packed {
      acmt_state_t state;
      logic        half_irq_en;
      logic        continuous_sampling_select;
      logic [2:0]  aqt;
      logic        slow_local;
      logic        slow_aux;
      logic [7:0]  dly_low;
      logic        dly_msb;
      logic        ext_en;
      logic [2:0]  div;
      logic [2:0]  div_cnt;
      logic        tick;
      logic [1:0]  src;
      logic [3:0]  chan;
      logic        flag;
      logic [1:0]  irq_sts;
      logic [1:0]  irq_msk;
      logic        irq;
      logic [8:0]  cnt;
      logic [7:0]  seq;
      logic        trig_prev;
      logic        dly_load;
      logic        sample;
      logic        convert;
      logic        slow;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } acmt_regs_t;

endpackage : acmt_pkg

// *** design/acmt_trig_delay.sv ***
// Purpose: Counts the external trigger delay in converter clock periods.
// Assumes: The tick is a one-cycle enable at the converter clock rate.
// Notes:   A zero delay gives done one cycle after the load.
module acmt_trig_delay
   import acmt_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   acmt_dly_if.dly   dly
);

   acmt_dly_t r_q;
   acmt_dly_t r_d;

   assign dly.done = r_q.done;

   always_comb begin
      r_d      = r_q;
      r_d.done = 1'b0;
      // RULE_12 count delay periods
      if (dly.load) begin
         r_d.count   = dly.value;
         r_d.running = (dly.value != 9'h000);
         r_d.done    = (dly.value == 9'h000);
      end else if (r_q.running && dly.tick) begin
         if (r_q.count == 9'h001) begin
            r_d.running = 1'b0;
            r_d.done    = 1'b1;
         end
         r_d.count = r_q.count - 9'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

endmodule // acmt_trig_delay

// *** dv/acmt_ctrl_sva.sv ***
// Purpose: Port checks of the converter control.
// Assumes: Conversion time counts system cycles; the window only grows with the divider.
// Notes:   Conversion length is counted in helper logic.
module acmt_ctrl_sva
   import acmt_pkg::*;
(
   input wire logic        CLK_IN,
   input wire logic        SYS_RST_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PREADY_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic [3:0]  TRIG_IN,
   input wire logic        IRQ_OUT,
   input wire logic        SAMPLE_OUT,
   input wire logic        CONVERT_OUT,
   input wire logic        SLOW_OUT,
   input wire logic [3:0]  CHANNEL_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] conv_q;
   always_ff @(posedge CLK_IN) begin
      conv_q <= (SYS_RST_IN || !CONVERT_OUT) ? 10'h000 : conv_q + 10'h001;
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   sequence s_setup; PSEL_IN && !PENABLE_IN; endsequence
   sequence s_access; PSEL_IN && PENABLE_IN; endsequence
   property p_wait_one; s_setup ##1 s_access |=> PREADY_OUT; endproperty
   a_wait_one: assert property (p_wait_one) else $error("ready not after one wait");
   property p_ready_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
   property p_err_zero; PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("error without ready or with data");
   property p_conv_len; $fell(CONVERT_OUT) |-> conv_q == (SLOW_OUT ? 10'h1DB : 10'h08C); endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
   property p_samp_conv; $fell(SAMPLE_OUT) |-> CONVERT_OUT; endproperty
   a_samp_conv: assert property (p_samp_conv) else $error("no conversion after sampling");
   property p_samp_min; $rose(SAMPLE_OUT) |-> SAMPLE_OUT [*6]; endproperty
   a_samp_min: assert property (p_samp_min) else $error("window below six clocks");
   property p_chan_write; $changed(CHANNEL_OUT) |-> $past(PREADY_OUT) || $past(PREADY_OUT, 2); endproperty
   a_chan_write: assert property (p_chan_write) else $error("channel moved without write");
   property p_slow_write; $changed(SLOW_OUT) |-> $past(PREADY_OUT) || $past(PREADY_OUT, 2); endproperty
   a_slow_write: assert property (p_slow_write) else $error("speed moved without write");
endmodule // acmt_ctrl_sva

bind acmt_ctrl acmt_ctrl_sva u_sva (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
   .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .TRIG_IN(TRIG_IN),
   .IRQ_OUT(IRQ_OUT), .SAMPLE_OUT(SAMPLE_OUT), .CONVERT_OUT(CONVERT_OUT), .SLOW_OUT(SLOW_OUT),
   .CHANNEL_OUT(CHANNEL_OUT));

// *** dv/acmt_trig_src.sv ***
// Purpose: Model of the pulse-width and start-pin trigger sources.
// Assumes: Clocked by the system clock; one source fires at a time.
// Notes:   Pulse length grows with the source number, from one to four cycles.
module acmt_trig_src
   import acmt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       go_in,
   input  wire logic [1:0] src_in,
   output      logic [3:0] trig_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left_q = 8'h00;
   always_ff @(posedge clk) begin
      if (go_in) begin
         left_q <= {6'h00, src_in} + 8'h01;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
   assign trig_out = (left_q != 8'h00) ? (4'h1 << src_in) : 4'h0;
endmodule // acmt_trig_src

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench of the converter control.
// Assumes: Divider zero, one tick per system clock, except in one window scenario.
// Notes:   Trigger pulses come from the source model.
`include "acmt_consts.svh"
module tb_top
   import acmt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] MT = `ACMT_ADDR_MODE_TIMING;
   localparam logic [11:0] DL = `ACMT_ADDR_DELAY_LOW;
   localparam logic [11:0] C0 = `ACMT_ADDR_CTRL_ZERO;
   localparam logic [11:0] C1 = `ACMT_ADDR_CTRL_ONE;
   localparam logic [11:0] C2 = `ACMT_ADDR_CTRL_TWO;
   localparam logic [11:0] AX = `ACMT_ADDR_AUX;
   localparam logic [11:0] ST = `ACMT_ADDR_IRQ_STATUS;
   localparam logic [11:0] MK = `ACMT_ADDR_IRQ_MASK;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [1:0]  src = 2'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, samp, conv, slow;
   logic [3:0]  trig, chan;
   int          miscompares = 0;
   int          n_checks = 0;
   acmt_ctrl uut (.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .TRIG_IN(trig), .IRQ_OUT(irq),
      .SAMPLE_OUT(samp), .CONVERT_OUT(conv), .SLOW_OUT(slow), .CHANNEL_OUT(chan));
   acmt_trig_src u_src (.clk(clk), .go_in(go), .src_in(src), .trig_out(trig));
   task automatic conclude;
      if (miscompares == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic limit(input int i, input int n);
      if (i >= n) begin
         chk(32'h1, 32'h0);
         conclude();
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= {24'h000000, d};
      @(posedge clk);
      pen <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      limit(i, 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic run(output int w, output int s, output int c);
      w = 0;
      s = 0;
      c = 0;
      while (samp !== 1'b1 && w < 1200) begin
         @(posedge clk);
         w++;
      end
      limit(w, 1200);
      while (samp === 1'b1 && s < 1000) begin
         s++;
         @(posedge clk);
      end
      limit(s, 1000);
      while (conv === 1'b1 && c < 1000) begin
         c++;
         @(posedge clk);
      end
      limit(c, 1000);
   endtask
   task automatic quiet;
      int i;
      for (i = 0; i < 400; i++) begin
         @(posedge clk);
         if (samp !== 1'b0) break;
      end
      chk(32'(i), 32'h190);
   endtask
   task automatic fire(input logic [1:0] sel);
      src <= sel;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic clr;
      wr(C0, 8'h00);
      wr(ST, 8'h03);
   endtask
   task automatic to_irq(inout int n);
      int i;
      logic p;
      p = 1'b0;
      for (i = 0; i < 3000; i++) begin
         @(posedge clk);
         if (p === 1'b1 && conv === 1'b0) n++;
         p = conv;
         if (irq === 1'b1) break;
      end
      limit(i, 3000);
   endtask
   task automatic s_regs;
      rdc(MT, 32'h0, 1'b0);
      rdc(DL, 32'h0, 1'b0);
      wr(MT, 8'hFF);
      rdc(MT, 32'h3F, 1'b0);
      wr(MT, 8'h00);
      rdc(12'h004, 32'h0, 1'b1);
   endtask
   task automatic s_soft;
      logic [3:0] ch [4] = '{4'h3, 4'h9, 4'h9, 4'hF};
      logic [2:0] aq [4] = '{3'h2, 3'h0, 3'h2, 3'h7};
      logic [31:0] xs [4] = '{32'h6, 32'h6, 32'hE, 32'h22};
      int w, s, c;
      wr(MK, 8'h01);
      for (int k = 0; k < 4; k++) begin
         wr(MT, {4'h0, aq[k], 1'b0});
         wr(C0, {4'h4, ch[k]});
         run(w, s, c);
         chk(32'(s), xs[k]);
         chk(32'(c), 32'h8C);
         chk({28'h0, chan}, {28'h0, ch[k]});
         repeat (3) @(posedge clk);
         chk({31'h0, irq}, 32'h1);
         rdc(C0, {24'h0, 4'h8, ch[k]}, 1'b0);
         wr(C0, {4'hC, ch[k]});
         quiet();
         clr();
      end
      wr(C1, 8'h10);
      wr(C0, 8'h43);
      run(w, s, c);
      chk(32'(s > 10 && s < 13), 32'h1);
      chk(32'(c), 32'h8C);
      wr(C1, 8'h00);
      clr();
      rdc(ST, 32'h0, 1'b0);
   endtask
   task automatic s_slow;
      int w, s, c;
      wr(MK, 8'h00);
      for (int k = 0; k < 2; k++) begin
         wr(k == 0 ? AX : MT, k == 0 ? 8'h10 : 8'h01);
         repeat (2) @(posedge clk);
         chk({31'h0, slow}, 32'h1);
         wr(C0, 8'h43);
         run(w, s, c);
         chk(32'(c), 32'h1DB);
         repeat (3) @(posedge clk);
         chk({31'h0, irq}, 32'h0);
         rdc(ST, 32'h1, 1'b0);
         wr(MK, 8'h01);
         repeat (3) @(posedge clk);
         chk({31'h0, irq}, 32'h1);
         wr(MK, 8'h00);
         wr(k == 0 ? AX : MT, 8'h00);
         clr();
      end
      chk({31'h0, slow}, 32'h0);
      wr(MK, 8'h01);
   endtask
   task automatic s_ext;
      int w, s, c;
      wr(C2, 8'h01);
      rdc(C2, 32'h1, 1'b0);
      wr(DL, 8'h05);
      wr(C1, 8'h02);
      rdc(C1, 32'h2, 1'b0);
      for (int k = 0; k < 4; k++) begin
         wr(C0, {2'b00, 2'(k), 4'h3});
         fire(2'(k));
         run(w, s, c);
         chk(32'(w > 261 && w < 268), 32'h1);
         clr();
      end
      wr(C0, 8'h03);
      fire(2'h2);
      quiet();
      wr(C0, 8'h43);
      fire(2'h0);
      run(w, s, c);
      chk(32'(w < 4), 32'h1);
      clr();
      quiet();
      wr(C1, 8'h00);
      wr(C0, 8'h03);
      fire(2'h0);
      quiet();
   endtask
   task automatic s_continuous_sampling_select(input logic half_done_irq_enable);
      int n;
      n = 0;
      wr(MT, {2'b00, half_done_irq_enable, 5'h10});
      wr(C0, 8'h43);
      if (half_done_irq_enable) begin
         to_irq(n);
         chk(32'(n), 32'h4);
         rdc(ST, 32'h3, 1'b0);
         wr(ST, 8'h03);
         repeat (3) @(posedge clk);
      end
      to_irq(n);
      chk(32'(n), 32'h8);
      rdc(ST, 32'h1, 1'b0);
      wr(MT, 8'h00);
      clr();
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      s_regs();
      s_soft();
      s_slow();
      s_ext();
      s_continuous_sampling_select(1'b0);
      s_continuous_sampling_select(1'b1);
      conclude();
   end
endmodule // tb_top
